// >>> logic/bmc_top.sv
// Purpose: word monitor and selective message monitor capture engine
// Assumes: decoder strobes one word per rx.valid, words at least 6 cycles apart
// Notes: shared RAM inside; host reaches it through host_req
`timescale 1ns/1ps
`include "bmc_cfg.svh"
module bmc_top #(
    parameter int AW = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // configuration
    input wire bmc_pkg::bmc_mode_t mode,
    input wire logic area_b_sel,
    input wire logic [4:0] own_rt_addr,
    input wire logic [1:0] cmd_stack_size,
    input wire logic [2:0] data_stack_size,
    // word monitor control
    input wire logic wm_start,
    input wire logic wm_stop,
    input wire logic [15:0] trigger_word,
    input wire logic trig_enable,
    input wire logic trig_start_sel,
    input wire logic trig_stop_sel,
    input wire logic monitor_pattern_match_irq_mask,
    input wire logic external_start_trigger_input,
    // received words
    input wire bmc_pkg::bmc_rx_t rx,
    // host RAM port
    input wire bmc_pkg::bmc_host_req_t host_req,
    output logic [15:0] host_rdata,
    // status and events
    output logic [15:0] data_stack_addr,
    output logic wm_active,
    output logic pattern_irq,
    output bmc_pkg::bmc_evt_t evt
);
    import bmc_pkg::*;

    // ***************************************************
    // constants and helpers
    // ***************************************************
    localparam logic [15:0] TOP = 16'((32'h0000_0001 << AW) - 32'h0000_0001);
    localparam logic [5:0] US_LAST = 6'(`BMC_CYC_PER_US - 1);

    function automatic logic [15:0] wa_inc(input logic [15:0] a);
        wa_inc = (a == TOP) ? 16'h0000 : a + 16'h0001; // R5
    endfunction

    function automatic logic [15:0] stk_next(input logic [15:0] p, input logic [15:0] m);
        stk_next = (p & ~m) | ((p + 16'h0001) & m); // R26
    endfunction

    function automatic logic stk_half(input logic [15:0] p, input logic [15:0] m);
        stk_half = (p & m) == ((m >> 1) + 16'h0001);
    endfunction

    function automatic logic [15:0] lut_addr(input bmc_cmd_t c);
        lut_addr = `BMC_LUT_BASE | {9'h000, c.rt, c.tr, c.sa[4]}; // R13
    endfunction

    function automatic logic [5:0] msg_words(input bmc_cmd_t c);
        logic [5:0] n;
        if (c.sa == `BMC_SA_MC0 || c.sa == `BMC_SA_MC31) begin
            n = c.wc[4] ? `BMC_MC_WORDS_DATA : `BMC_MC_WORDS_NODATA;
        end else if (c.wc == 5'h00) begin
            n = `BMC_WC_ZERO_WORDS;
        end else begin
            n = {1'b0, c.wc} + 6'h01;
        end
        msg_words = n;
    endfunction

    // ***************************************************
    // state
    // ***************************************************
    bmc_state_t st_q, st_d;
    logic [15:0] wa_q, cp_q, dp_q, tag_q;
    bmc_cmd_t cmd_q;
    logic [5:0] rem_q, us_q;
    logic [7:0] gap_q;
    logic first_q, store_q, stop_q, ext_q;
    logic ea_en, ea_we;
    logic [15:0] ea_addr, ea_wdata, ram_rd;
    logic ext_s;

    // ***************************************************
    // decode
    // ***************************************************
    wire bmc_cmd_t rx_cmd = bmc_cmd_t'(rx.word);
    wire sel_mode = (mode == BMC_SEL) || (mode == BMC_COMB);
    wire ext_rise = ext_s && !ext_q; // R9
    wire pat_hit = rx.valid && (mode == BMC_WORD) && (rx.word == trigger_word); // R6
    wire trig_start = trig_enable && trig_start_sel && pat_hit; // R8
    wire trig_stop = trig_enable && trig_stop_sel && pat_hit; // R8
    wire wm_go = wm_start || ext_rise || trig_start;
    wire wm_wr = rx.valid && !wm_stop && (mode == BMC_WORD); // R23
    wire cmd_in = rx.valid && rx.cmd_sync && !rx.err; // R10
    wire own_hit = (mode == BMC_COMB) && ((rx_cmd.rt == own_rt_addr) || (rx_cmd.rt == `BMC_BCAST_ADDR)); // R11
    wire lut_bit = ram_rd[cmd_q.sa[3:0]]; // R14
    wire rtrt = first_q && !cmd_q.tr && rx.cmd_sync && rx_cmd.tr && (rx_cmd.rt != cmd_q.rt); // R17
    wire msg_end = (rx.valid && (rem_q == `BMC_REM_LAST) && !rtrt) || (gap_q >= `BMC_NORESP_US); // R10
    wire [15:0] cp_loc = area_b_sel ? `BMC_MCS_PTR_B : `BMC_MCS_PTR_A; // R18 R19
    wire [15:0] dp_loc = area_b_sel ? `BMC_MDS_PTR_B : `BMC_MDS_PTR_A; // R18 R19
    wire [15:0] cs_m = 16'(`BMC_CS_MIN << {cmd_stack_size, 1'b0}) - 16'h0001; // R21
    wire [15:0] ds_m = 16'(`BMC_DS_MIN << data_stack_size) - 16'h0001; // R22
    wire [15:0] cp_nx = stk_next(cp_q, cs_m);
    wire [15:0] dp_nx = stk_next(dp_q, ds_m);
    wire cs_step = (st_q == S_DESC) || (st_q == S_DESC2);
    wire ds_step = (st_q == S_MSG) && rx.valid && store_q;

    // ***************************************************
    // next state
    // ***************************************************
    always_comb begin
        st_d = st_q;
        case (st_q)
            S_IDLE: begin
                if (mode == BMC_WORD && wm_go) begin
                    st_d = S_WM_PTR; // R9
                end else if (sel_mode) begin
                    st_d = S_SM_IDLE;
                end
            end
            S_WM_PTR: st_d = S_WM_LD;
            S_WM_LD: st_d = S_WM_RUN;
            S_WM_RUN: begin
                if (mode != BMC_WORD || wm_stop) begin
                    st_d = S_IDLE;
                end else if (rx.valid) begin
                    st_d = S_WM_TAG;
                end
            end
            S_WM_TAG: st_d = stop_q ? S_IDLE : S_WM_RUN; // R8
            S_SM_IDLE: begin
                if (!sel_mode) begin
                    st_d = S_IDLE;
                end else if (cmd_in) begin
                    st_d = own_hit ? S_MSG : S_LUT;
                end
            end
            S_LUT: st_d = lut_bit ? S_CP : S_MSG; // R15
            S_CP: st_d = S_DP;
            S_DP: st_d = S_DESC;
            S_DESC: st_d = S_DESC2;
            S_DESC2: st_d = S_MSG;
            S_MSG: begin
                if (msg_end) begin
                    st_d = store_q ? S_WB_C : S_SM_IDLE;
                end
            end
            S_WB_C: st_d = S_WB_D;
            S_WB_D: st_d = S_SM_IDLE;
            default: st_d = S_IDLE;
        endcase
    end

    // ***************************************************
    // engine RAM port
    // ***************************************************
    always_comb begin
        ea_en = 1'b0;
        ea_we = 1'b0;
        ea_addr = 16'h0000;
        ea_wdata = 16'h0000;
        case (st_q)
            S_WM_PTR: begin
                ea_en = 1'b1;
                ea_addr = area_b_sel ? `BMC_WM_PTR_B : `BMC_WM_PTR_A; // R1
            end
            S_WM_RUN: begin
                ea_en = wm_wr;
                ea_we = wm_wr;
                ea_addr = wa_q; // R4
                ea_wdata = rx.word; // R2
            end
            S_WM_TAG: begin
                ea_en = 1'b1;
                ea_we = 1'b1;
                ea_addr = wa_q;
                ea_wdata = tag_q; // R2
            end
            S_SM_IDLE: begin
                ea_en = cmd_in && !own_hit && sel_mode;
                ea_addr = lut_addr(rx_cmd); // R13
            end
            S_LUT: begin
                ea_en = lut_bit;
                ea_addr = cp_loc; // R12
            end
            S_CP: begin
                ea_en = 1'b1;
                ea_addr = dp_loc; // R12
            end
            S_DESC: begin
                ea_en = 1'b1;
                ea_we = 1'b1;
                ea_addr = cp_q;
                ea_wdata = cmd_q; // R20
            end
            S_DESC2: begin
                ea_en = 1'b1;
                ea_we = 1'b1;
                ea_addr = cp_q;
                ea_wdata = dp_q; // R16
            end
            S_MSG: begin
                ea_en = ds_step;
                ea_we = ds_step;
                ea_addr = dp_q;
                ea_wdata = rx.word; // R16
            end
            S_WB_C: begin
                ea_en = 1'b1;
                ea_we = 1'b1;
                ea_addr = cp_loc;
                ea_wdata = cp_q; // R26
            end
            S_WB_D: begin
                ea_en = 1'b1;
                ea_we = 1'b1;
                ea_addr = dp_loc;
                ea_wdata = dp_q; // R26
            end
            default: ;
        endcase
    end

    // ***************************************************
    // submodules
    // ***************************************************
    bmc_sync u_ext (
        .sys_clk(sys_clk),
        .rst(rst),
        .d(external_start_trigger_input),
        .q(ext_s)
    );

    bmc_ram #(.AW(AW), .DW(16)) u_ram (
        .sys_clk(sys_clk),
        .rst(rst),
        .a_en(ea_en),
        .a_we(ea_we),
        .a_addr(ea_addr[AW-1:0]),
        .a_wdata(ea_wdata),
        .a_rdata(ram_rd),
        .b_en(host_req.en),
        .b_we(host_req.we),
        .b_addr(host_req.addr[AW-1:0]),
        .b_wdata(host_req.wdata),
        .b_rdata(host_rdata)
    );

    // ***************************************************
    // registers
    // ***************************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q <= S_IDLE;
            ext_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ext_q <= ext_s;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wa_q <= 16'h0000;
            tag_q <= 16'h0000;
            stop_q <= 1'b0;
        end else if (st_q == S_WM_LD) begin
            wa_q <= ram_rd; // R1
            stop_q <= 1'b0;
        end else if ((st_q == S_WM_RUN && wm_wr) || st_q == S_WM_TAG) begin
            wa_q <= wa_inc(wa_q); // R4
            tag_q <= {rx.bus_b, rx.err, rx.cmd_sync, 5'h00, gap_q}; // R24
            stop_q <= (st_q == S_WM_RUN) ? trig_stop : stop_q;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cp_q <= 16'h0000;
            dp_q <= 16'h0000;
        end else begin
            if (st_q == S_CP) begin
                cp_q <= ram_rd; // R18
            end else if (cs_step) begin
                cp_q <= cp_nx; // R26
            end
            if (st_q == S_DP) begin
                dp_q <= ram_rd; // R18
            end else if (ds_step) begin
                dp_q <= dp_nx; // R26
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cmd_q <= '0;
            rem_q <= 6'h00;
            first_q <= 1'b0;
            store_q <= 1'b0;
        end else if (st_q == S_SM_IDLE && cmd_in) begin
            cmd_q <= rx_cmd;
            rem_q <= msg_words(rx_cmd); // R10
            first_q <= 1'b1;
            store_q <= 1'b0;
        end else if (st_q == S_LUT) begin
            store_q <= lut_bit; // R15
        end else if (st_q == S_MSG && rx.valid) begin
            rem_q <= rtrt ? rem_q + 6'h01 : rem_q - 6'h01; // R17
            first_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            us_q <= 6'h00;
            gap_q <= 8'h00;
        end else if (rx.valid) begin
            us_q <= 6'h00;
            gap_q <= 8'h00; // R24
        end else begin
            us_q <= (us_q == US_LAST) ? 6'h00 : us_q + 6'h01;
            gap_q <= (us_q == US_LAST && gap_q != 8'hFF) ? gap_q + 8'h01 : gap_q;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            data_stack_addr <= 16'h0000;
            wm_active <= 1'b0;
            pattern_irq <= 1'b0;
            evt <= '0;
        end else begin
            data_stack_addr <= (mode == BMC_WORD) ? wa_q : dp_q; // R3
            wm_active <= (st_q == S_WM_RUN) || (st_q == S_WM_TAG);
            pattern_irq <= pat_hit && monitor_pattern_match_irq_mask; // R7
            evt.eom <= (st_q == S_WB_D); // R25
            evt.cs_half <= cs_step && stk_half(cp_nx, cs_m); // R25
            evt.cs_full <= cs_step && ((cp_nx & cs_m) == 16'h0000); // R25
            evt.ds_half <= ds_step && stk_half(dp_nx, ds_m); // R25
            evt.ds_full <= ds_step && ((dp_nx & ds_m) == 16'h0000); // R25
        end
    end

    // ***************************************************
    // assertions
    // ***************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_wm_ptr;
        st_q == S_WM_PTR |-> ea_en && !ea_we && ea_addr == (area_b_sel ? `BMC_WM_PTR_B : `BMC_WM_PTR_A);
    endproperty
    a_wm_ptr: assert property (p_wm_ptr) else $error("word monitor pointer read wrong"); // R1

    property p_wm_pair;
        (st_q == S_WM_RUN && wm_wr) |=> st_q == S_WM_TAG && ea_we && ea_addr == wa_inc($past(ea_addr));
    endproperty
    a_wm_pair: assert property (p_wm_pair) else $error("tag word not at next address"); // R2

    property p_wm_addr;
        $past(mode == BMC_WORD) |-> data_stack_addr == $past(wa_q);
    endproperty
    a_wm_addr: assert property (p_wm_addr) else $error("data stack address not the counter"); // R3

    property p_wm_wrap;
        (st_q == S_WM_TAG && wa_q == TOP) |=> wa_q == 16'h0000;
    endproperty
    a_wm_wrap: assert property (p_wm_wrap) else $error("counter did not wrap"); // R5

    property p_pat_irq;
        pat_hit |=> pattern_irq == $past(monitor_pattern_match_irq_mask);
    endproperty
    a_pat_irq: assert property (p_pat_irq) else $error("pattern interrupt gating wrong"); // R7

    property p_trig_stop;
        (st_q == S_WM_RUN && wm_wr && trig_stop) |-> ##2 st_q == S_IDLE;
    endproperty
    a_trig_stop: assert property (p_trig_stop) else $error("stop on trigger missed"); // R8

    property p_ext_start;
        (st_q == S_IDLE && mode == BMC_WORD && ext_rise) |=> st_q == S_WM_PTR ##2 st_q == S_WM_RUN;
    endproperty
    a_ext_start: assert property (p_ext_start) else $error("external trigger did not start"); // R9

    property p_own;
        (st_q == S_SM_IDLE && sel_mode && cmd_in && own_hit) |=> st_q == S_MSG && !ea_we;
    endproperty
    a_own: assert property (p_own) else $error("own address message monitored"); // R11

    property p_lut;
        st_q == S_LUT |-> $past(ea_en) && $past(ea_addr) == lut_addr(cmd_q);
    endproperty
    a_lut: assert property (p_lut) else $error("lookup address wrong"); // R13

    property p_reject;
        (st_q == S_LUT && !lut_bit) |=> (!ea_we throughout (st_q == S_MSG)[*1]);
    endproperty
    a_reject: assert property (p_reject) else $error("rejected message stored"); // R15

    property p_accept;
        (st_q == S_LUT && lut_bit) |-> ##3 ea_we && ea_addr == cp_q && ea_wdata == cmd_q ##1 ea_wdata == dp_q;
    endproperty
    a_accept: assert property (p_accept) else $error("descriptor entry wrong"); // R16

    property p_cp_read;
        st_q == S_CP |-> $past(ea_addr) == $past(cp_loc) && ea_addr == dp_loc;
    endproperty
    a_cp_read: assert property (p_cp_read) else $error("stack pointer words wrong"); // R18

    property p_wb;
        st_q == S_WB_C |=> ea_we && ea_addr == dp_loc && ea_wdata == dp_q ##1 evt.eom;
    endproperty
    a_wb: assert property (p_wb) else $error("pointer write back or end event wrong"); // R26

    c_wm_run: cover property (st_q == S_WM_LD ##1 st_q == S_WM_RUN);
    c_accept: cover property (st_q == S_WB_D);
    c_reject: cover property (st_q == S_LUT && !lut_bit);
    c_ds_full: cover property (evt.ds_full);
endmodule // bmc_top

// >>> logic/bmc_cfg.svh
// Purpose: fixed addresses, sizes and timing of the bus monitor capture block
// Assumes: 16-bit shared RAM words, 50 MHz sys_clk
// Notes: included by the top design file of the block only
//
// What this block does
// R1: word monitor starts at area pointer word
// R2: store bus word, then its tag
// R3: write address readable as data stack address
// R4: counter overwrites stack pointer words freely
// R5: address counter wraps to zero at top
// R6: one 16-bit trigger compare word
// R7: pattern interrupt only when mask bit set
// R8: trigger enable; match starts or stops monitor
// R9: external rising edge starts word monitor
// R10: tell command from status without host
// R11: combined mode skips own and broadcast address
// R12: own monitor stacks, pointers at fixed words
// R13: lookup address from base, address, T/R, SA4
// R14: low subaddress bits select lookup bit
// R15: lookup bit zero: store nothing
// R16: bit one: descriptor entry, then data stack
// R17: RT-to-RT: store transmit command too
// R18: fixed command and data pointer words
// R19: fixed words avoid terminal fixed words
// R20: receive: command to descriptor, data+status stacked
// R21: command stack size 256/1K/4K/16K
// R22: data stack size 512 through 64K
// R23: capture every word of both buses
// R24: tag holds channel, validity, gap time
// R25: end-of-message and stack rollover events
// R26: pointers wrap in stack, written back
// R27: host initialises pointers and table first
`ifndef BMC_CFG_SVH
`define BMC_CFG_SVH

// ***************************************************
// fixed shared RAM words
// ***************************************************
`define BMC_WM_PTR_A 16'h0100
`define BMC_WM_PTR_B 16'h0104
`define BMC_MCS_PTR_A 16'h0102
`define BMC_MDS_PTR_A 16'h0103
`define BMC_MCS_PTR_B 16'h0106
`define BMC_MDS_PTR_B 16'h0107
`define BMC_LUT_BASE 16'h0280

// ***************************************************
// stack sizes and message shapes
// ***************************************************
`define BMC_CS_MIN 16'h0100
`define BMC_DS_MIN 16'h0200
`define BMC_BCAST_ADDR 5'h1F
`define BMC_SA_MC0 5'h00
`define BMC_SA_MC31 5'h1F
`define BMC_WC_ZERO_WORDS 6'h21
`define BMC_MC_WORDS_DATA 6'h02
`define BMC_MC_WORDS_NODATA 6'h01
`define BMC_REM_LAST 6'h01

// ***************************************************
// timing
// ***************************************************
`define BMC_CLK_PERIOD_NS 20
`define BMC_US_NS 1000
`define BMC_CYC_PER_US (`BMC_US_NS / `BMC_CLK_PERIOD_NS)
`define BMC_NORESP_US 8'h28

`endif

// >>> logic/bmc_pkg.sv
// Purpose: types of the bus monitor capture block
// Assumes: nothing
// Notes: constants live in bmc_cfg.svh
package bmc_pkg;

    typedef enum logic [1:0] {
        BMC_OFF = 2'b00,
        BMC_WORD = 2'b01,
        BMC_SEL = 2'b10,
        BMC_COMB = 2'b11
    } bmc_mode_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0000,
        S_WM_PTR = 4'b0001,
        S_WM_LD = 4'b0010,
        S_WM_RUN = 4'b0011,
        S_WM_TAG = 4'b0100,
        S_SM_IDLE = 4'b0101,
        S_LUT = 4'b0110,
        S_CP = 4'b0111,
        S_DP = 4'b1000,
        S_DESC = 4'b1001,
        S_DESC2 = 4'b1010,
        S_MSG = 4'b1011,
        S_WB_C = 4'b1100,
        S_WB_D = 4'b1101
    } bmc_state_t;

    typedef struct packed {
        logic [4:0] rt;
        logic tr;
        logic [4:0] sa;
        logic [4:0] wc;
    } bmc_cmd_t;

    typedef struct packed {
        logic valid;
        logic bus_b;
        logic cmd_sync;
        logic err;
        logic [15:0] word;
    } bmc_rx_t;

    typedef struct packed {
        logic en;
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } bmc_host_req_t;

    typedef struct packed {
        logic eom;
        logic cs_half;
        logic cs_full;
        logic ds_half;
        logic ds_full;
    } bmc_evt_t;

endpackage

// >>> logic/bmc_sync.sv
// Purpose: two-stage synchroniser for a pin level
// Assumes: input asynchronous to sys_clk
// Notes: only the second stage leaves the module
`timescale 1ns/1ps
module bmc_sync (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // level
    input wire logic d,
    output logic q
);
    logic s1_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b0;
            q <= 1'b0;
        end else begin
            s1_q <= d;
            q <= s1_q;
        end
    end
endmodule // bmc_sync

// >>> logic/bmc_ram.sv
// Purpose: shared RAM, engine port and host port
// Assumes: one clock, registered read data
// Notes: same-address writes in one cycle: host wins
`timescale 1ns/1ps
module bmc_ram #(
    parameter int AW = 16,
    parameter int DW = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // engine port
    input wire logic a_en,
    input wire logic a_we,
    input wire logic [AW-1:0] a_addr,
    input wire logic [DW-1:0] a_wdata,
    output logic [DW-1:0] a_rdata,
    // host port
    input wire logic b_en,
    input wire logic b_we,
    input wire logic [AW-1:0] b_addr,
    input wire logic [DW-1:0] b_wdata,
    output logic [DW-1:0] b_rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge sys_clk) begin
        if (a_en && a_we) begin
            mem[a_addr] <= a_wdata;
        end
        if (b_en && b_we) begin
            mem[b_addr] <= b_wdata;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            a_rdata <= '0;
            b_rdata <= '0;
        end else begin
            if (a_en) begin
                a_rdata <= mem[a_addr];
            end
            if (b_en) begin
                b_rdata <= mem[b_addr];
            end
        end
    end
endmodule // bmc_ram

// >>> tb/bmc_bus_src.sv
// Purpose: bus word source standing for the other terminals
// Assumes: one word per call, bench keeps the gap
// Notes: idle lines show the inverse of the last word
`timescale 1ns/1ps
module bmc_bus_src import bmc_pkg::*; (
    // clock
    input wire logic sys_clk,
    // received word
    output bmc_pkg::bmc_rx_t rx
);
    initial rx = '0;
    task automatic send(input logic [15:0] w, input logic b, input logic s);
        @(negedge sys_clk);
        rx <= '{valid: 1'b1, bus_b: b, cmd_sync: s, err: 1'b0, word: w};
        @(negedge sys_clk);
        rx <= '{valid: 1'b0, bus_b: ~b, cmd_sync: ~s, err: 1'b1, word: ~w};
    endtask
endmodule // bmc_bus_src

// >>> tb/bmc_top_tb.sv
// Purpose: self-checking bench of bmc_top
// Assumes: AW=12, 4K RAM
// Notes: expected RAM held in exp_mem, compared by host reads
`timescale 1ns/1ps
module bmc_top_tb;
    import bmc_pkg::*;
    logic sys_clk = 0, rst = 1, wm_start = 0, wm_stop = 0, trig_enable = 0, mask = 0, ext = 0, trig_start = 0;
    logic [15:0] trig = 16'h0000, dsa, rdata, got;
    logic irq, act;
    bmc_mode_t mode = BMC_OFF;
    bmc_rx_t rx;
    bmc_host_req_t hreq = '0;
    bmc_evt_t evt;
    int num_errors = 0, total_checks = 0, cyc = 0, eoms = 0, w_adr;
    logic [15:0] exp_mem[int], exp_msk[int];
    bmc_top #(.AW(12)) bmc_top_i (.sys_clk(sys_clk), .rst(rst), .mode(mode), .area_b_sel(1'b0),
        .own_rt_addr(5'h00), .cmd_stack_size(2'h1), .data_stack_size(3'h2), .wm_start(wm_start),
        .wm_stop(wm_stop), .trigger_word(trig), .trig_enable(trig_enable), .trig_start_sel(trig_start),
        .trig_stop_sel(trig_enable), .monitor_pattern_match_irq_mask(mask),
        .external_start_trigger_input(ext), .rx(rx), .host_req(hreq), .host_rdata(rdata),
        .data_stack_addr(dsa), .wm_active(act), .pattern_irq(irq), .evt(evt));
    bmc_bus_src bmc_bus_src_i (.sys_clk(sys_clk), .rx(rx));
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (evt.eom === 1'b1) eoms = eoms + 1;
        if (cyc == 5000) begin
            num_errors++;
            wrap_up;
        end
    end
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        hreq <= '{en: 1'b1, we: 1'b1, addr: a, wdata: d};
        @(negedge sys_clk);
        hreq <= '0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(negedge sys_clk);
        hreq <= '{en: 1'b1, we: 1'b0, addr: a, wdata: 16'h0000};
        @(negedge sys_clk);
        hreq <= '0;
        @(negedge sys_clk);
        got = rdata;
    endtask
    // one word monitor word and its model entry
    task automatic mon(input logic [15:0] w, input logic b, input logic s);
        bmc_bus_src_i.send(w, b, s);
        chk({15'h0000, irq}, {15'h0000, w == trig && mask});
        exp_mem[w_adr] = w;
        exp_msk[w_adr] = 16'hFFFF;
        exp_mem[(w_adr + 1) % 4096] = {b, 1'b0, s, 13'h0000};
        exp_msk[(w_adr + 1) % 4096] = 16'hE000;
        w_adr = (w_adr + 2) % 4096;
        repeat (20) @(negedge sys_clk);
        chk(dsa, w_adr[15:0]);
    endtask
    // command, two data words, status
    task automatic sel(input logic [15:0] c, input logic acc);
        logic [15:0] m[4];
        m = '{c, 16'($urandom), 16'($urandom), {c[15:11], 11'h000}};
        for (int i = 0; i < 4; i++) begin
            bmc_bus_src_i.send(m[i], 1'b0, i == 0 || i == 3);
            repeat (10) @(negedge sys_clk);
        end
        if (acc) begin
            exp_mem[16'h0400] = c;
            exp_mem[16'h0401] = 16'h0800;
            for (int i = 0; i < 3; i++) exp_mem[16'h0800 + i] = m[i + 1];
            for (int a = 16'h0400; a < 16'h0402; a++) exp_msk[a] = 16'hFFFF;
            for (int a = 16'h0800; a < 16'h0803; a++) exp_msk[a] = 16'hFFFF;
        end
        repeat (10) @(negedge sys_clk);
    endtask
    initial begin
        void'($urandom(2293));
        w_adr = 16'h0FFC;
        repeat (2) @(negedge sys_clk);
        rst = 0;
        wr(16'h0100, 16'h0FFC);
        mode = BMC_WORD;
        trig = 16'hA5A5;
        wm_start = 1;
        @(negedge sys_clk);
        wm_start = 0;
        repeat (4) @(negedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            mask = (i != 3);
            mon(i >= 2 ? trig : 16'($urandom), i[0], i[1]);
        end
        $display("word monitor test done");
        trig_enable = 1;
        mon(trig, 1'b1, 1'b0);
        chk({15'h0000, act}, 16'h0000);
        trig_start = 1;
        bmc_bus_src_i.send(trig, 1'b0, 1'b0);
        repeat (10) @(negedge sys_clk);
        chk({15'h0000, act}, 16'h0001);
        trig_enable = 0;
        trig_start = 0;
        wm_stop = 1;
        repeat (4) @(negedge sys_clk);
        chk({15'h0000, act}, 16'h0000);
        wm_stop = 0;
        ext = 1;
        repeat (10) @(negedge sys_clk);
        chk({15'h0000, act}, 16'h0001);
        $display("trigger test done");
        wm_stop = 1;
        rst = 1;
        repeat (2) @(negedge sys_clk);
        rst = 0;
        wm_stop = 0;
        mode = BMC_SEL;
        wr(16'h0102, 16'h0400);
        wr(16'h0103, 16'h0800);
        wr(16'h0294, 16'h0008);
        sel({5'h05, 1'b0, 5'h03, 5'h02}, 1'b1);
        chk(16'(eoms), 16'h0001);
        sel({5'h05, 1'b0, 5'h04, 5'h02}, 1'b0);
        chk(dsa, 16'h0803);
        mode = BMC_COMB;
        sel({5'h00, 1'b0, 5'h03, 5'h02}, 1'b0);
        chk(dsa, 16'h0803);
        exp_mem[16'h0102] = 16'h0402;
        exp_mem[16'h0103] = 16'h0803;
        exp_msk[16'h0102] = 16'hFFFF;
        exp_msk[16'h0103] = 16'hFFFF;
        foreach (exp_mem[a]) begin
            rd(a[15:0]);
            chk(got & exp_msk[a], exp_mem[a]);
        end
        $display("selective monitor test done");
        wrap_up;
    end
endmodule // bmc_top_tb
